//--- tb/key_matrix_scan_encoder_checker.sv
// port checks for the key matrix scanner
// assumes bind to key_matrix_scan_encoder
`timescale 1ns/1ns
`default_nettype none
module key_matrix_scan_encoder_checker #(
    parameter integer ROWS = 5,
    parameter integer CODE_BITS = 5
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [ROWS-1:0] i_row_sense,
    input wire logic [3:0] o_column_drive_n,
    input wire logic [3:0] o_column_drive_oe,
    input wire logic i_output_enable_n,
    input wire logic [CODE_BITS-1:0] o_key_code,
    input wire logic [CODE_BITS-1:0] o_key_code_oe,
    input wire logic o_key_valid_flag
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // ****************
    // checks
    // ****************
    a_col_onehot: assert property ($past(i_rst_n) |-> $onehot(o_column_drive_oe))
        else $error("column drive not one-hot");
    a_col_low: assert property (o_column_drive_n == 4'h0)
        else $error("column data not low");
    a_col_rotate: assert property ($past(i_rst_n, 2)
        && $changed(o_column_drive_oe)
        |-> o_column_drive_oe == {$past(o_column_drive_oe[2:0]),
        $past(o_column_drive_oe[3])})
        else $error("column order wrong");
    a_col_freeze: assert property (o_key_valid_flag && $past(o_key_valid_flag)
        |-> $stable(o_column_drive_oe))
        else $error("column moved while key held");
    a_valid_row: assert property ($rose(o_key_valid_flag) |-> $past(~&i_row_sense))
        else $error("valid without low row");
    a_code_col: assert property ($rose(o_key_valid_flag)
        |-> o_column_drive_oe == (4'h1 << o_key_code[1:0]))
        else $error("code column wrong");
    a_fall_release: assert property (o_key_valid_flag && &i_row_sense
        |=> !o_key_valid_flag)
        else $error("valid kept after release");
    a_code_hold: assert property ($past(i_rst_n) && !$rose(o_key_valid_flag)
        |-> $stable(o_key_code))
        else $error("code changed without entry");
    a_oe_follow: assert property ($past(i_rst_n)
        |-> o_key_code_oe == {CODE_BITS{~$past(i_output_enable_n)}})
        else $error("code enable wrong");
    c_entry: cover property ($rose(o_key_valid_flag));
    c_release: cover property ($fell(o_key_valid_flag));
    c_oe_on: cover property ($fell(i_output_enable_n));
endmodule // key_matrix_scan_encoder_checker
bind key_matrix_scan_encoder key_matrix_scan_encoder_checker #(.ROWS(ROWS),
    .CODE_BITS(CODE_BITS)) i_chk (.i_mclk, .i_rst_n, .i_row_sense,
    .o_column_drive_n, .o_column_drive_oe, .i_output_enable_n, .o_key_code,
    .o_key_code_oe, .o_key_valid_flag);
`default_nettype wire

//--- tb/keypad_model.sv
// keypad model: one switch closed at a time, rows pulled high
// assumes column oe high means that column is pulled low
`timescale 1ns/1ns
`default_nettype none
module keypad_model (
    // matrix
    input wire logic [3:0] i_col_oe,
    output logic [4:0] o_row,
    // switch
    input wire logic [4:0] i_key,
    input wire logic i_down
);
    // closed switch joins its row to its column
    assign o_row = ~({4'h0, i_down & i_col_oe[i_key[1:0]]} << i_key[4:2]);
endmodule // keypad_model
`default_nettype wire

//--- tb/tb_key_matrix_scan_encoder.sv
// bench: every key pressed with bounce, code and valid checked
// assumes the keypad model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb_key_matrix_scan_encoder;
    logic i_mclk = 0, i_rst_n = 0, oen = 1, down = 0, valid;
    logic [4:0] key = 0, row, code, code_oe;
    logic [3:0] col_n, col_oe;
    int err_total = 0, samples_checked = 0, k, q[$];
    initial forever #4 i_mclk = ~i_mclk;
    // scan stepped every 4 master clocks, much faster than the default of 125
    key_matrix_scan_encoder #(.SCAN_DIV(4), .DEBOUNCE_STEPS(8'h02)) i_dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_row_sense(row),
        .o_column_drive_n(col_n), .o_column_drive_oe(col_oe),
        .i_output_enable_n(oen), .o_key_code(code), .o_key_code_oe(code_oe),
        .o_key_valid_flag(valid));
    keypad_model i_pad (.i_col_oe(col_oe), .o_row(row), .i_key(key),
        .i_down(down));
    // ****************
    // tasks
    // ****************
    task finish_test;
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task wait_flag(input logic v);
        int n;
        n = 0;
        while (valid !== v && n < 200) begin
            @(posedge i_mclk) #1;
            n++;
        end
        `CHK(valid, v)
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        k = $urandom(8892);
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1;
        @(posedge i_mclk) #1;
        `CHK(col_oe, 4'h1)
        for (k = 0; k < 20; k++) begin
            @(posedge i_mclk);
            key <= k[4:0];
            oen <= $urandom % 2;
            // bounces shorter than the debounce span
            repeat (2 + $urandom % 6) begin
                @(posedge i_mclk) down <= 1;
                @(posedge i_mclk) down <= 0;
            end
            @(posedge i_mclk) #1;
            `CHK(valid, 1'b0)
            q.push_back(k);
            @(posedge i_mclk) down <= 1;
            wait_flag(1);
            `CHK(code, 5'(q[0]))
            // odd keys: host sets the enable once to the inverted valid flag
            if (k % 2 == 1) @(posedge i_mclk) oen <= ~valid;
            repeat (2) @(posedge i_mclk);
            #1 `CHK(code_oe, {5{~oen}})
            @(posedge i_mclk) down <= 0;
            wait_flag(0);
            `CHK(code, 5'(q.pop_front()))
        end
        finish_test;
    end
    initial begin
        #200000;
        err_total++;
        finish_test;
    end
endmodule // tb_key_matrix_scan_encoder
`default_nettype wire

//--- verilog/key_matrix_scan_encoder.v
// key matrix scanner: 4 columns by 4 or 5 rows, debounced key code out
// assumes row inputs synchronous to i_mclk, low meaning a closed switch
//
// Operation
// - idle: columns pulled low one at a time, each a quarter of the cycle
// - a 2-bit counter stepped by the scan tick decodes one-hot to columns
// - rows read high when open; low row means closed switch on column
// - row low on active column freezes counter, column stays driven low
// - row low starts debounce timer and locks out other rows
// - key code from frozen column and encoded row, 4 or 5 bits
// - debounce expiry with row low latches code and raises valid flag
// - row high before expiry resets timer and resumes scan from there
// - closure accepted only after one unbroken debounce period low
// - after release, timer runs out before any new closure is seen
// - second key ignored until first released and timer run out
// - code driven out only while active-low output enable is low
`timescale 1ns/1ns
`default_nettype none
`include "keyscan_map.vh"

module key_matrix_scan_encoder #(
    parameter integer ROWS = 5,
    parameter integer CODE_BITS = 5,
    parameter integer SCAN_DIV = `KS_SCAN_DIV,
    parameter [7:0] DEBOUNCE_STEPS = `KS_DEBOUNCE_STEPS
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rst_n,
    // matrix
    input wire [ROWS-1:0] i_row_sense,
    output reg [3:0] o_column_drive_n,
    output reg [3:0] o_column_drive_oe,
    // host side
    input wire i_output_enable_n,
    output reg [CODE_BITS-1:0] o_key_code,
    output reg [CODE_BITS-1:0] o_key_code_oe,
    output reg o_key_valid_flag
);

    // ************************************************************
    // states
    // ************************************************************
    localparam [3:0] ST_SCAN = 4'b0001;
    localparam [3:0] ST_BOUNCE = 4'b0010;
    localparam [3:0] ST_HELD = 4'b0100;
    localparam [3:0] ST_RELEASE = 4'b1000;

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [`KS_COL_BITS-1:0] col_q;
    reg [`KS_COL_BITS-1:0] col_d;
    reg [2:0] row_q;
    reg [2:0] row_d;
    reg [7:0] timer_q;
    reg [7:0] timer_d;
    reg [CODE_BITS-1:0] code_q;
    reg [CODE_BITS-1:0] code_d;
    reg valid_d;
    wire tick;

    scan_tick #(
        .DIV(SCAN_DIV)
    ) u_tick (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .o_tick(tick)
    );

    // ************************************************************
    // row priority encoder
    // ************************************************************
    reg any_low;
    reg [2:0] low_row;
    integer r;
    always @* begin
        any_low = 1'b0;
        low_row = 3'h0;
        for (r = ROWS - 1; r >= 0; r = r - 1) begin
            if (!i_row_sense[r]) begin
                any_low = 1'b1;
                low_row = r[2:0];
            end
        end
    end

    // ************************************************************
    // locked row watch
    // ************************************************************
    // only the locked row is watched once detection starts; the select
    // is a loop so an index past the top row reads as an open switch
    reg locked_low;
    integer w;
    always @* begin
        locked_low = 1'b0;
        for (w = 0; w < ROWS; w = w + 1) begin
            if (row_q == w[2:0]) begin
                locked_low = ~i_row_sense[w];
            end
        end
    end

    wire [4:0] full_code = {row_q, col_q};

    // ************************************************************
    // control
    // ************************************************************
    // scan: rotate columns, first low row wins and is locked
    // bounce: count ticks with the locked row low, any high restarts
    // held: code latched, wait for the locked row to open
    // release: let the timer run out so release bounce is ignored
    always @* begin
        state_d = state_q;
        col_d = col_q;
        row_d = row_q;
        timer_d = timer_q;
        code_d = code_q;
        valid_d = o_key_valid_flag;
        case (state_q)
            ST_SCAN: begin
                if (any_low) begin
                    row_d = low_row;
                    timer_d = 8'h00;
                    state_d = ST_BOUNCE;
                end else if (tick) begin
                    col_d = col_q + 2'h1;
                end
            end
            ST_BOUNCE: begin
                if (!locked_low) begin
                    timer_d = 8'h00;
                    state_d = ST_SCAN;
                end else if (timer_q >= DEBOUNCE_STEPS) begin
                    code_d = full_code[CODE_BITS-1:0];
                    valid_d = 1'b1;
                    state_d = ST_HELD;
                end else if (tick) begin
                    timer_d = timer_q + 8'h01;
                end
            end
            ST_HELD: begin
                if (!locked_low) begin
                    valid_d = 1'b0;
                    timer_d = 8'h00;
                    state_d = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (timer_q >= DEBOUNCE_STEPS) begin
                    state_d = ST_SCAN;
                end else if (tick) begin
                    timer_d = timer_q + 8'h01;
                end
            end
            default: begin
                state_d = ST_SCAN;
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_SCAN;
            col_q <= 2'h0;
            row_q <= 3'h0;
            timer_q <= 8'h00;
            code_q <= `KS_CODE_RESET;
            o_key_valid_flag <= 1'b0;
        end else begin
            state_q <= state_d;
            col_q <= col_d;
            row_q <= row_d;
            timer_q <= timer_d;
            code_q <= code_d;
            o_key_valid_flag <= valid_d;
        end
    end

    // ************************************************************
    // pin drivers
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_col
            always @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_column_drive_n[g] <= 1'b0;
                    o_column_drive_oe[g] <= 1'b0;
                end else begin
                    o_column_drive_n[g] <= 1'b0;
                    o_column_drive_oe[g] <= (col_d == g);
                end
            end
        end
        for (g = 0; g < CODE_BITS; g = g + 1) begin : g_code
            always @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_key_code[g] <= 1'b0;
                    o_key_code_oe[g] <= 1'b0;
                end else begin
                    o_key_code[g] <= code_d[g];
                    o_key_code_oe[g] <= ~i_output_enable_n;
                end
            end
        end
    endgenerate

endmodule // key_matrix_scan_encoder

`default_nettype wire

//--- verilog/keyscan_map.vh
// keypad scanner constants: timing counts and code layout
// assumes inclusion by the scanner modules only
`ifndef KEYSCAN_MAP_VH
`define KEYSCAN_MAP_VH

// master clock period in ns
`define KS_MCLK_PERIOD_NS 8
// scan step period in ns (one column slot at the default rate)
`define KS_SCAN_STEP_NS 1000
// master clocks per scan step, rounded down
`define KS_SCAN_DIV ((`KS_SCAN_STEP_NS) / (`KS_MCLK_PERIOD_NS))
// default debounce period in scan steps
`define KS_DEBOUNCE_STEPS 16
// width of the column counter
`define KS_COL_BITS 2
// reset value of the held key code
`define KS_CODE_RESET 5'h00

`endif

//--- verilog/scan_tick.v
// scan step generator: one-cycle pulse every DIV master clocks
// assumes a single free-running master clock
`timescale 1ns/1ns
`default_nettype none

module scan_tick #(
    parameter integer DIV = 125
) (
    // clock and reset
    input wire i_mclk,
    input wire i_rst_n,
    // step pulse
    output reg o_tick
);

    reg [15:0] cnt_q;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 16'h0000;
            o_tick <= 1'b0;
        end else if (cnt_q == DIV[15:0] - 16'h0001) begin
            cnt_q <= 16'h0000;
            o_tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            o_tick <= 1'b0;
        end
    end

endmodule // scan_tick

`default_nettype wire
